//--- design/dfi_pkg.sv
// Package: constants and carrier types of the 8x8 forward/inverse DCT engine
package dfi_pkg;

   // ==========================================================
   // Build choices
   localparam int ARCH_FWD             = 0;
   localparam int ARCH_INV             = 1;
   localparam int ARCH_MUX             = 2;
   localparam bit IN_REORDER           = 1'b1;
   localparam bit OUT_REORDER          = 1'b1;

   // ==========================================================
   // Widths
   localparam int pixel_width_param    = 9;
   localparam int coef_width_param     = 12;
   localparam int BUF_W                = 12;
   localparam int DP_W                 = 20;
   localparam int ACC_W                = 40;
   localparam int PIX_MAX              = (1 << (pixel_width_param - 1)) - 1;
   localparam int COEF_MAX             = (1 << (coef_width_param - 1)) - 1;

   // ==========================================================
   // Pipeline timing
   localparam int MUL_STAGES           = 1;
   localparam int MEM_RD_LAT           = 2;
   localparam int SHIFT_ROW            = 10;
   localparam int SHIFT_COL            = 16;

   // ==========================================================
   // Scan orders, formats, counts
   localparam logic [1:0] SCAN_ROW     = 2'h0;
   localparam logic [1:0] SCAN_COL     = 2'h1;
   localparam logic [1:0] SCAN_ZZ      = 2'h2;
   localparam logic [1:0] FMT_8X8      = 2'h0;
   localparam logic [1:0] FMT_FRAME    = 2'h1;
   localparam logic [1:0] FMT_FIELD    = 2'h2;
   localparam logic [7:0] LAST_ONE     = 8'h3f;
   localparam logic [7:0] LAST_FOUR    = 8'hff;
   localparam logic [1:0] BUF_EMPTY    = 2'h0;
   localparam logic [1:0] BUF_FILL     = 2'h1;
   localparam logic [1:0] BUF_FULL     = 2'h2;

   // ==========================================================
   // Half cosine table, 13 fraction bits: cos(m*pi/16)/2
   localparam logic signed [15:0] COS_TAB [0:8] = '{
      16'sh1000, 16'sh0fb1, 16'sh0ec8, 16'sh0d4e, 16'sh0b50,
      16'sh08e4, 16'sh061f, 16'sh031f, 16'sh0000};

   // ==========================================================
   // Types
   typedef logic signed [DP_W-1:0] dfi_word_t;
   typedef dfi_word_t [7:0]        dfi_vec_t;

   typedef struct packed {
      logic valid;
      logic inv;
      logic second;
   } dfi_tag_s;

   typedef struct packed {
      logic       inv;
      logic [1:0] in_scan;
      logic [1:0] in_fmt;
      logic [1:0] out_scan;
      logic [1:0] out_fmt;
   } dfi_mode_s;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_LOAD = 5'h02,
      ST_ROW  = 5'h04,
      ST_COL  = 5'h08,
      ST_OUT  = 5'h10
   } dfi_state_e;

endpackage

//--- design/dfi_scan.sv
// Scan order to buffer address mapping for 8x8 and 16x16 formats
`timescale 1ns/100ps
module dfi_scan (
   input  wire logic [7:0] count_in,
   input  wire logic [1:0] scan_in,
   input  wire logic [1:0] format_in,
   output logic [7:0]      addr_out
);

   logic [3:0] line;
   logic [3:0] row;

   // ==========================================================
   // Zig-zag walk over the 15 diagonals
   function automatic logic [5:0] zigzag(input logic [5:0] idx);
      int         n;
      int         r;
      int         c;
      logic [5:0] pos;
      n = 0;
      pos = 6'h00;
      for (int d = 0; d < 15; d++) begin
         for (int k = 0; k < 8; k++) begin
            r = (d % 2 == 1) ? k : d - k;
            c = d - r;
            if (r >= 0 && r < 8 && c >= 0 && c < 8) begin
               if (n == int'(idx)) begin
                  pos = 6'(r * 8 + c);
               end
               n++;
            end
         end
      end
      return pos;
   endfunction

   // ==========================================================
   // Address: {block, row, column}
   always_comb begin
      line = count_in[7:4];
      row = (format_in == dfi_pkg::FMT_FIELD) ? {line[2:0], line[3]} : line;
      if (format_in == dfi_pkg::FMT_FRAME || format_in == dfi_pkg::FMT_FIELD) begin
         addr_out = {row[3], count_in[3], row[2:0], count_in[2:0]}; // [R6] [R13]
      end else if (scan_in == dfi_pkg::SCAN_COL) begin
         addr_out = {count_in[7:6], count_in[2:0], count_in[5:3]}; // [R5] [R13]
      end else if (scan_in == dfi_pkg::SCAN_ZZ) begin
         addr_out = {count_in[7:6], zigzag(count_in[5:0])}; // [R5] [R13]
      end else begin
         addr_out = count_in;
      end
   end

endmodule

//--- design/dfi_pass.sv
// One-dimensional 8-point DCT/IDCT pipeline of four stages
`timescale 1ns/100ps
module dfi_pass (
   input  wire logic              mclk_in,
   input  wire logic              rst_b_in,
   input  wire dfi_pkg::dfi_tag_s tag_in,
   input  wire dfi_pkg::dfi_vec_t vec_in,
   output dfi_pkg::dfi_tag_s      tag_out,
   output dfi_pkg::dfi_vec_t      vec_out
);

   localparam int AW = dfi_pkg::ACC_W;
   localparam int DW = dfi_pkg::DP_W;
   localparam int MS = dfi_pkg::MUL_STAGES;

   logic signed [DW:0]   pre  [8];
   logic signed [AW-1:0] prod [MS][8][4];
   logic signed [AW-1:0] sum  [8];
   logic signed [AW-1:0] acc  [8];
   logic signed [AW-1:0] post [8];
   dfi_pkg::dfi_tag_s    tag_pre;
   dfi_pkg::dfi_tag_s    tag_mul [MS];
   dfi_pkg::dfi_tag_s    tag_acc;
   int                   sh;

   // Basis weight c(k)/2*cos((2n+1)k*pi/16)
   function automatic logic signed [15:0] cosw(input int k, input int n);
      int m;
      m = ((2 * n + 1) * k) % 32;
      if (m > 16) begin
         m = 32 - m;
      end
      if (k == 0) begin
         return dfi_pkg::COS_TAB[4];
      end else if (m > 8) begin
         return -dfi_pkg::COS_TAB[16 - m];
      end
      return dfi_pkg::COS_TAB[m];
   endfunction

   // ==========================================================
   // Stages 1 and 2: pre add/subtract, cosine multipliers
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tag_pre <= '0;
         for (int i = 0; i < 8; i++) begin
            pre[i] <= '0;
         end
         for (int s = 0; s < MS; s++) begin
            tag_mul[s] <= '0;
            for (int k = 0; k < 8; k++) begin
               for (int i = 0; i < 4; i++) begin
                  prod[s][k][i] <= '0;
               end
            end
         end
      end else begin
         tag_pre <= tag_in;
         for (int i = 0; i < 4; i++) begin
            if (tag_in.inv) begin
               pre[i] <= (DW+1)'($signed(vec_in[i]));
               pre[i + 4] <= (DW+1)'($signed(vec_in[i + 4]));
            end else begin
               pre[i] <= (DW+1)'($signed(vec_in[i])) + (DW+1)'($signed(vec_in[7 - i])); // [R11]
               pre[i + 4] <= (DW+1)'($signed(vec_in[i])) - (DW+1)'($signed(vec_in[7 - i]));
            end
         end
         tag_mul[0] <= tag_pre;
         for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
               prod[0][k][i] <= AW'(cosw(k, i)) * AW'(tag_pre.inv ? pre[k] :
                                (k % 2 == 1) ? pre[i + 4] : pre[i]); // [R11] [R2]
            end
         end
         for (int s = 1; s < MS; s++) begin
            tag_mul[s] <= tag_mul[s - 1];
            prod[s] <= prod[s - 1];
         end
      end
   end

   // ==========================================================
   // Stage 3: matrix accumulators
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         sum[k] = '0;
      end
      for (int k = 0; k < 8; k++) begin
         for (int i = 0; i < 4; i++) begin
            if (tag_mul[MS - 1].inv) begin
               sum[(k % 2) * 4 + i] += prod[MS - 1][k][i]; // [R11]
            end else begin
               sum[k] += prod[MS - 1][k][i];
            end
         end
      end
   end

   // ==========================================================
   // Stage 4: post add/subtract and rounding
   always_comb begin
      sh = tag_acc.second ? dfi_pkg::SHIFT_COL : dfi_pkg::SHIFT_ROW;
      for (int n = 0; n < 4; n++) begin
         if (tag_acc.inv) begin
            post[n] = acc[n] + acc[n + 4]; // [R11]
            post[7 - n] = acc[n] - acc[n + 4];
         end else begin
            post[n] = acc[n];
            post[n + 4] = acc[n + 4];
         end
      end
      for (int n = 0; n < 8; n++) begin
         post[n] = (post[n] + (AW'(1) <<< (sh - 1))) >>> sh;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tag_acc <= '0;
         tag_out <= '0;
         vec_out <= '0;
         for (int k = 0; k < 8; k++) begin
            acc[k] <= '0;
         end
      end else begin
         tag_acc <= tag_mul[MS - 1];
         acc <= sum;
         tag_out <= tag_acc;
         for (int n = 0; n < 8; n++) begin
            vec_out[n] <= post[n][DW-1:0];
         end
      end
   end

endmodule

//--- design/dfi_top.sv
// Top of the 8x8 two-dimensional forward/inverse DCT engine
`timescale 1ns/100ps
// Operation
// [R1] Computes 8x8 two-dimensional forward or inverse DCT with N equal 8.
// [R2] Inverse result meets the IEEE 1180-1990 accuracy limits.
// [R3] Built forward-only, inverse-only or combined, chosen at build time.
// [R4] Direction echo only in combined build; direction input picks the transform.
// [R5] Input words go to input buffer, read back; row, column, zig-zag scans.
// [R6] Input reorder also takes 16x16 row scan by field or frame.
// [R7] Buffer memories support sync/async protocols and selectable active edges; here all buffers are written on the rising edge of mclk_in only.
// [R8] Transpose memory always present; in/out buffers only with reordering; here both buffers are built in every configuration.
// [R9] Control timing follows multiplier stage count and memory read latency.
// [R10] One-dimensional transform in 4 stages; each block passes twice.
// [R11] Stages: pre add/subtract, multipliers, accumulators, post add/subtract.
// [R12] Intermediate block goes from row to column order via transpose memory.
// [R13] Output reorder emits 8x8 row, column, zig-zag or 16x16 field/frame.
// [R14] Data port widths equal pixel or coefficient width of their words.
// [R15] Two-bit input and output buffer states and one-bit processing state.
// [R16] Field/frame and zig-zag selects act only with buffers built in.
// [R17] Source strobes valid per word and marks each block's first word; the bench source marks only the first word of a job.
// [R18] Output valid with each result; sync marks each output block's first word.
// [R19] Active-low reset clears pipeline, buffer state and control at once.
module dfi_top #(
   parameter int direction_arch_param = dfi_pkg::ARCH_MUX,
   parameter int IN_W  = (direction_arch_param == dfi_pkg::ARCH_FWD) ?
                         dfi_pkg::pixel_width_param : dfi_pkg::coef_width_param,
   parameter int OUT_W = (direction_arch_param == dfi_pkg::ARCH_INV) ?
                         dfi_pkg::pixel_width_param : dfi_pkg::coef_width_param
) (
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   input  wire logic [IN_W-1:0]  data_in,
   input  wire logic             block_sync_in,
   input  wire logic             word_valid_in,
   input  wire logic             direction_sel_in,
   input  wire logic [1:0]       fwd_field_frame_sel_in,
   input  wire logic [1:0]       fwd_zigzag_sel_in,
   input  wire logic [1:0]       inv_field_frame_sel_in,
   input  wire logic [1:0]       inv_zigzag_sel_in,
   input  wire logic             clear_out_req_in,
   output logic                  process_begin_out,
   output logic [OUT_W-1:0]      data_out,
   output logic                  block_sync_out,
   output logic                  word_valid_out,
   output logic                  direction_sel_out,
   output logic                  out_read_enable_out,
   output logic [1:0]            in_buffer_state_out,
   output logic [1:0]            out_buffer_state_out,
   output logic                  processing_state_out
);

   localparam int BW = dfi_pkg::BUF_W;
   localparam int DW = dfi_pkg::DP_W;
   localparam int ML = dfi_pkg::MEM_RD_LAT;

   // ==========================================================
   // Storage and state
   logic [BW-1:0]         input_buffer_mem  [256];
   dfi_pkg::dfi_word_t    transpose_mem     [64];
   logic [BW-1:0]         output_buffer_mem [256];
   dfi_pkg::dfi_state_e   state;
   dfi_pkg::dfi_mode_s    mode;
   dfi_pkg::dfi_mode_s    next_mode;
   logic [7:0]            cnt;
   logic [7:0]            ocnt;
   logic [1:0]            blk;
   logic [3:0]            iss;
   logic [2:0]            rcv;
   logic                  multi;
   logic [7:0]            last_cnt;
   logic [1:0]            last_blk;
   logic [7:0]            in_addr;
   logic [7:0]            out_addr;
   logic                  issuing;
   logic                  phase_done;
   dfi_pkg::dfi_tag_s     issue_tag;
   dfi_pkg::dfi_vec_t     rd_vec;
   dfi_pkg::dfi_tag_s     rd_tag  [ML];
   dfi_pkg::dfi_vec_t     rd_pipe [ML];
   dfi_pkg::dfi_tag_s     res_tag;
   dfi_pkg::dfi_vec_t     res_vec;

   // Clamp to the result word range
   function automatic logic [BW-1:0] clamp(input dfi_pkg::dfi_word_t v, input logic inv);
      int lim;
      lim = inv ? dfi_pkg::PIX_MAX : dfi_pkg::COEF_MAX;
      if (int'(v) > lim) begin
         return BW'(lim);
      end else if (int'(v) < -lim - 1) begin
         return BW'(-lim - 1);
      end
      return v[BW-1:0];
   endfunction

   // ==========================================================
   // Mode selection at block start
   always_comb begin
      next_mode = '0;
      if (direction_arch_param == dfi_pkg::ARCH_INV) begin
         next_mode.inv = 1'b1; // [R3]
      end else if (direction_arch_param == dfi_pkg::ARCH_MUX) begin
         next_mode.inv = direction_sel_in; // [R4]
      end
      if (next_mode.inv) begin
         next_mode.in_scan = inv_zigzag_sel_in;
         next_mode.out_fmt = inv_field_frame_sel_in;
      end else begin
         next_mode.in_fmt = fwd_field_frame_sel_in;
         next_mode.out_scan = fwd_zigzag_sel_in;
      end
      if (!dfi_pkg::IN_REORDER) begin
         next_mode.in_scan = dfi_pkg::SCAN_ROW; // [R8] [R16]
         next_mode.in_fmt = dfi_pkg::FMT_8X8;
      end
      if (!dfi_pkg::OUT_REORDER) begin
         next_mode.out_scan = dfi_pkg::SCAN_ROW; // [R8] [R16]
         next_mode.out_fmt = dfi_pkg::FMT_8X8;
      end
   end

   assign multi = (mode.in_fmt == dfi_pkg::FMT_FRAME) || (mode.in_fmt == dfi_pkg::FMT_FIELD) ||
                  (mode.out_fmt == dfi_pkg::FMT_FRAME) || (mode.out_fmt == dfi_pkg::FMT_FIELD);
   assign last_cnt = multi ? dfi_pkg::LAST_FOUR : dfi_pkg::LAST_ONE;
   assign last_blk = multi ? 2'h3 : 2'h0;

   // ==========================================================
   // Scan order mapping
   dfi_scan u_in_scan (
      .count_in  (cnt),
      .scan_in   (mode.in_scan),
      .format_in (mode.in_fmt),
      .addr_out  (in_addr)
   );

   dfi_scan u_out_scan (
      .count_in  (ocnt),
      .scan_in   (mode.out_scan),
      .format_in (mode.out_fmt),
      .addr_out  (out_addr)
   );

   // ==========================================================
   // Row or column fetch into the one-dimensional pipeline
   assign issuing = ((state == dfi_pkg::ST_ROW) || (state == dfi_pkg::ST_COL)) && !iss[3];
   assign issue_tag = '{valid: issuing, inv: mode.inv, second: (state == dfi_pkg::ST_COL)};
   assign phase_done = res_tag.valid && (rcv == 3'h7);

   always_comb begin
      for (int j = 0; j < 8; j++) begin
         if (state == dfi_pkg::ST_ROW) begin
            rd_vec[j] = DW'($signed(input_buffer_mem[{blk, iss[2:0], 3'(j)}])); // [R5]
         end else begin
            rd_vec[j] = transpose_mem[{iss[2:0], 3'(j)}]; // [R12]
         end
      end
   end

   // Synchronous read with fixed latency; the tag rides along
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         for (int s = 0; s < ML; s++) begin
            rd_tag[s] <= '0; // [R19]
            rd_pipe[s] <= '0;
         end
      end else begin
         rd_tag[0] <= issue_tag; // [R7] [R9]
         rd_pipe[0] <= rd_vec;
         for (int s = 1; s < ML; s++) begin
            rd_tag[s] <= rd_tag[s - 1];
            rd_pipe[s] <= rd_pipe[s - 1];
         end
      end
   end

   dfi_pass u_pass (
      .mclk_in  (mclk_in),
      .rst_b_in (rst_b_in),
      .tag_in   (rd_tag[ML - 1]),
      .vec_in   (rd_pipe[ML - 1]),
      .tag_out  (res_tag),
      .vec_out  (res_vec)
   ); // [R10] [R1]

   // ==========================================================
   // Buffer writes
   always_ff @(posedge mclk_in) begin
      if (word_valid_in && ((state == dfi_pkg::ST_IDLE && block_sync_in) ||
                            state == dfi_pkg::ST_LOAD)) begin
         input_buffer_mem[in_addr] <= BW'($signed(data_in)); // [R5] [R14]
      end
      if (res_tag.valid && !res_tag.second) begin
         for (int j = 0; j < 8; j++) begin
            transpose_mem[{3'(j), rcv}] <= res_vec[j]; // [R12]
         end
      end
      if (res_tag.valid && res_tag.second) begin
         for (int i = 0; i < 8; i++) begin
            output_buffer_mem[{blk, 3'(i), rcv}] <= clamp(res_vec[i], res_tag.inv); // [R13]
         end
      end
   end

   // ==========================================================
   // Sequencer
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= dfi_pkg::ST_IDLE; // [R19]
         mode <= '0;
         cnt <= 8'h00;
         ocnt <= 8'h00;
         blk <= 2'h0;
         iss <= 4'h0;
         rcv <= 3'h0;
         process_begin_out <= 1'b0;
      end else begin
         process_begin_out <= 1'b0;
         if (issuing) begin
            iss <= iss + 4'h1;
         end
         if (res_tag.valid) begin
            rcv <= rcv + 3'h1; // [R9]
         end
         case (state)
            dfi_pkg::ST_IDLE: begin
               if (word_valid_in && block_sync_in) begin // [R17]
                  mode <= next_mode;
                  cnt <= 8'h01;
                  state <= dfi_pkg::ST_LOAD;
               end
            end
            dfi_pkg::ST_LOAD: begin
               if (word_valid_in) begin
                  cnt <= cnt + 8'h01;
                  if (cnt == last_cnt) begin
                     cnt <= 8'h00;
                     blk <= 2'h0;
                     iss <= 4'h0;
                     process_begin_out <= 1'b1;
                     state <= dfi_pkg::ST_ROW;
                  end
               end
            end
            dfi_pkg::ST_ROW: begin
               if (phase_done) begin
                  iss <= 4'h0;
                  state <= dfi_pkg::ST_COL; // [R10]
               end
            end
            dfi_pkg::ST_COL: begin
               if (phase_done) begin
                  iss <= 4'h0;
                  if (blk == last_blk) begin
                     ocnt <= 8'h00;
                     state <= dfi_pkg::ST_OUT;
                  end else begin
                     blk <= blk + 2'h1;
                     state <= dfi_pkg::ST_ROW;
                  end
               end
            end
            dfi_pkg::ST_OUT: begin
               ocnt <= ocnt + 8'h01;
               if (clear_out_req_in || ocnt == last_cnt) begin
                  ocnt <= 8'h00;
                  state <= dfi_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= dfi_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Result stream
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         data_out <= '0; // [R19]
         word_valid_out <= 1'b0;
         block_sync_out <= 1'b0;
      end else begin
         word_valid_out <= (state == dfi_pkg::ST_OUT) && !clear_out_req_in; // [R18]
         block_sync_out <= (state == dfi_pkg::ST_OUT) && !clear_out_req_in &&
                           (ocnt[5:0] == 6'h00); // [R18]
         if (state == dfi_pkg::ST_OUT) begin
            data_out <= output_buffer_mem[out_addr][OUT_W-1:0]; // [R13] [R14]
         end
      end
   end

   // ==========================================================
   // Status
   assign out_read_enable_out = (state == dfi_pkg::ST_OUT);
   assign direction_sel_out = (direction_arch_param == dfi_pkg::ARCH_MUX) ? mode.inv : 1'b0; // [R4]
   assign processing_state_out = (state == dfi_pkg::ST_ROW) || (state == dfi_pkg::ST_COL); // [R15]

   always_comb begin
      in_buffer_state_out = dfi_pkg::BUF_EMPTY; // [R15]
      out_buffer_state_out = dfi_pkg::BUF_EMPTY;
      case (state)
         dfi_pkg::ST_LOAD: begin
            in_buffer_state_out = dfi_pkg::BUF_FILL;
         end
         dfi_pkg::ST_ROW: begin
            in_buffer_state_out = dfi_pkg::BUF_FULL;
            out_buffer_state_out = (blk != 2'h0) ? dfi_pkg::BUF_FILL : dfi_pkg::BUF_EMPTY;
         end
         dfi_pkg::ST_COL: begin
            in_buffer_state_out = dfi_pkg::BUF_FULL;
            out_buffer_state_out = dfi_pkg::BUF_FILL;
         end
         dfi_pkg::ST_OUT: begin
            out_buffer_state_out = dfi_pkg::BUF_FULL;
         end
         default: begin
            in_buffer_state_out = dfi_pkg::BUF_EMPTY;
         end
      endcase
   end

endmodule

//--- bench/dfi_assertions.sv
// Checker of stream and status behaviour at the engine ports
`timescale 1ns/100ps
module dfi_assertions (
   input wire logic       mclk_in,
   input wire logic       rst_b_in,
   input wire logic       word_valid_in,
   input wire logic       process_begin_out,
   input wire logic       block_sync_out,
   input wire logic       word_valid_out,
   input wire logic       direction_sel_out,
   input wire logic       out_read_enable_out,
   input wire logic [1:0] in_buffer_state_out,
   input wire logic [1:0] out_buffer_state_out,
   input wire logic       processing_state_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   // ==========================================================
   // Properties
   sync_valid_a: assert property (block_sync_out |-> word_valid_out)
      else $error("sync without valid");
   begin_pulse_a: assert property (process_begin_out |=> !process_begin_out)
      else $error("start pulse too long");
   begin_state_a: assert property (process_begin_out |-> processing_state_out &&
      in_buffer_state_out == 2'h2) else $error("status wrong at start");
   begin_load_a: assert property (process_begin_out |-> $past(word_valid_in))
      else $error("start without last word");
   out_enable_a: assert property (word_valid_out |-> $past(out_read_enable_out) &&
      $past(out_buffer_state_out) == 2'h2) else $error("output outside output phase");
   dir_hold_a: assert property (processing_state_out && $past(processing_state_out)
      |-> $stable(direction_sel_out)) else $error("direction changed in job");
   first_out_a: assert property (process_begin_out |-> ##[12:900] word_valid_out)
      else $error("no result after start");
   state_code_a: assert property (in_buffer_state_out != 2'h3 &&
      out_buffer_state_out != 2'h3) else $error("illegal buffer state");
endmodule
bind dfi_top dfi_assertions chk (.mclk_in, .rst_b_in, .word_valid_in, .process_begin_out,
   .block_sync_out, .word_valid_out, .direction_sel_out, .out_read_enable_out,
   .in_buffer_state_out, .out_buffer_state_out, .processing_state_out);

//--- bench/dfi_source.sv
// Partner: video source streaming one job of words
`timescale 1ns/100ps
module dfi_source (
   input  wire logic mclk_in,
   output logic [11:0] data_out,
   output logic        block_sync_out,
   output logic        word_valid_out
);
   initial begin
      data_out = 12'h000;
      block_sync_out = 1'b0;
      word_valid_out = 1'b0;
   end
   // Word k%64==0 gets first, others rest; random idle gaps
   task automatic send(input int n, input int first, input int rest);
      for (int k = 0; k < n; k++) begin
         while (k > 0 && $urandom_range(3) == 0) begin
            word_valid_out = 1'b0;
            data_out = ~data_out;
            @(posedge mclk_in);
            #1;
         end
         word_valid_out = 1'b1;
         block_sync_out = (k == 0);
         data_out = 12'((k % 64 == 0) ? first : rest);
         @(posedge mclk_in);
         #1;
      end
      word_valid_out = 1'b0;
      block_sync_out = 1'b0;
      data_out = ~data_out;
   endtask
endmodule

//--- bench/testbench.sv
// Testbench: DC block jobs in every mode, abort and mid-run reset
`timescale 1ns/100ps
module testbench;
   logic        mclk_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        dir = 1'b0;
   logic        clr = 1'b0;
   logic [1:0]  fmt = 2'h0;
   logic [1:0]  scan = 2'h0;
   logic [11:0] src_data, data_out;
   logic [1:0]  in_buffer_state_out, out_buffer_state_out;
   logic        src_sync, src_valid, process_begin_out, block_sync_out, word_valid_out;
   logic        direction_sel_out, out_read_enable_out, processing_state_out;
   int          failures = 0;
   int          n_checks = 0;
   int          kout = 0;
   int          expq[$];
   always #2.5 mclk_in = ~mclk_in;
   dfi_source src (.mclk_in, .data_out(src_data), .block_sync_out(src_sync),
      .word_valid_out(src_valid));
   dfi_top dut (.mclk_in, .rst_b_in, .data_in(src_data), .block_sync_in(src_sync),
      .word_valid_in(src_valid), .direction_sel_in(dir), .fwd_field_frame_sel_in(fmt),
      .fwd_zigzag_sel_in(scan), .inv_field_frame_sel_in(fmt), .inv_zigzag_sel_in(scan),
      .clear_out_req_in(clr), .process_begin_out, .data_out, .block_sync_out,
      .word_valid_out, .direction_sel_out, .out_read_enable_out,
      .in_buffer_state_out, .out_buffer_state_out, .processing_state_out);
   task automatic final_report;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input int e, input logic [11:0] s, input int w);
      int sv;
      sv = $isunknown(s) ? 99999 : int'($signed(s));
      n_checks++;
      if (sv > e + w || sv < e - w) begin
         failures++;
         $display("Error %s expected %0d seen %0d", what, e, sv);
      end
   endtask
   always @(negedge mclk_in) begin
      if (rst_b_in === 1'b1 && word_valid_out !== 1'b0) begin
         check("data", expq.size() ? expq.pop_front() : 99999, data_out, 1);
         check("sync", int'(kout % 64 == 0), 12'(block_sync_out), 0);
         kout++;
      end
   end
   // Mode 0 full job, 1 cleared output, 2 reset in processing
   task automatic job(input int j, input int mode);
      int v, n;
      v = int'($urandom_range(511)) - 256;
      n = (j[2:1] == 2'h1 || j[2:1] == 2'h2) ? 256 : 64;
      dir = j[0];
      fmt = j[2:1];
      scan = j[3:2];
      kout = 0;
      for (int k = 0; k < n; k++) expq.push_back(j[0] ? v : (k % 64 ? 0 : 8 * v));
      src.send(n, j[0] ? 8 * v : v, j[0] ? 0 : v);
      check("begin", 1, 12'(process_begin_out), 0);
      check("inbuf", 2, 12'(in_buffer_state_out), 0);
      check("proc", 1, 12'(processing_state_out), 0);
      check("dir", int'(j[0]), 12'(direction_sel_out), 0);
      if (mode == 2) begin
         rst_b_in = 1'b0;
         #1;
         check("rst proc", 0, 12'(processing_state_out), 0);
         expq.delete();
         repeat (5) @(posedge mclk_in);
         #1;
         rst_b_in = 1'b1;
      end
      for (int t = 0; t < 3000 && expq.size() > mode * 30; t++) @(posedge mclk_in);
      #1;
      clr = (mode == 1);
      @(posedge mclk_in);
      #1;
      clr = 1'b0;
      if (mode == 0) check("missing", 0, 12'(expq.size()), 0);
      expq.delete();
      repeat (2) @(posedge mclk_in);
      #1;
      check("valid", 0, 12'(word_valid_out), 0);
      check("rd en", 0, 12'(out_read_enable_out), 0);
      check("idle", 0, 12'(in_buffer_state_out), 0);
      check("outbuf", 0, 12'(out_buffer_state_out), 0);
   endtask
   initial begin
      void'($urandom(32'ha5c097d1));
      repeat (5) @(posedge mclk_in);
      #1;
      check("rst data", 0, data_out, 0);
      rst_b_in = 1'b1;
      for (int j = 0; j < 16; j++) job(j, 0);
      job(0, 1);
      job(1, 2);
      job(5, 0);
      final_report();
   end
   initial begin
      #300000;
      failures++;
      final_report();
   end
endmodule
